// [rtl/tpu_timer.sv]
`timescale 1ns/1ns
// Functional notes
// [R1] Mode register bit 7: 0 plain timer, 1 auto-reload PWM.
// [R2] 8-bit counter increments once per tick clock rising edge.
// [R3] Tick, clear and gate each selectable internal or external pin.
// [R4] 16-bit prescaler divides master or external clock into tick clock.
// [R5] Bit 0 low holds counter at zero; writing 1 releases it.
// [R6] Bit 2 is internal run gate, start/stop in timer mode.
// [R7] Bit 1 selects level or edge recognition of external clear.
// [R8] Bit 3 level gate: run while high, capture count when low.
// [R9] Edge gate: first rising edge after clear starts, next stops.
// [R10] Timer output frequency is tick frequency over compare value.
// [R11] Wave select: 50% square wave or one-tick pulse.
// [R12] PWM mode loads reload value each time counting restarts.
// [R13] PWM output high from start until count reaches compare.
// [R14] PWM period 255 minus reload ticks, high compare minus reload.
// [R15] Compare 255 always high; 0 or below reload always low. Code drives one high cycle each time counting starts.
// [R16] Compare changes take effect after current counting phase.
// [R17] Reload writes act immediately; following cycles work normally.
// [R18] PWM output holds its level while run gate is off.
// [R19] Output pins high impedance while cleared or in reset.
// [R20] Bit 6 picks stop or edge interrupts; bits 5:4 pick edge.
// [R21] Rising-edge interrupt also raised when counting starts.
// [R22] Stop irq with external gate fires on low gate; clear fires falling.
// [R23] Status bit 1 running, bit 0 released from clear.
// [R24] Timer mode counter restarts from zero on reaching compare.
module tpu_timer
   import tpu_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // External pins
   input wire logic externalTickInput,
   input wire logic counterClearInput,
   input wire logic runGateInput,
   output logic outputPinTrue,
   output logic outputPinTrueOe_n,
   output logic outputPinInverted,
   output logic outputPinInvertedOe_n,
   // Interrupt request
   output logic irqPulse
);
   // ******************************************
   // Registers
   // ******************************************
   logic [7:0] modeCtl_reg;
   logic [16:0] prescaleCtl_reg;
   logic [2:0] sourceCtl_reg;
   logic [7:0] compare_reg;
   logic [7:0] reload_reg;
   logic [7:0] compareShadow_reg;
   logic [7:0] count_reg;
   logic [7:0] capturedCount_reg;
   logic [15:0] prescaleCnt_reg;
   logic [2:0] tickSync_reg;
   logic [2:0] clearSync_reg;
   logic [2:0] gateSync_reg;
   logic gateToggle_reg;
   logic running_reg;
   logic clearHold_reg;
   logic wave_reg;
   logic waitReq_reg;
   logic [31:0] readData_reg;
   logic irq_reg;
   logic invOut_reg;

   // ******************************************
   // Bus decode
   // ******************************************
   wire busReq = read | write;
   wire busTake = busReq & ~waitReq_reg;
   wire busWrite = write & busTake;
   wire [31:0] readMux;

   function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
      hit = (addr == off);
   endfunction

   // [R23] status bits
   assign readMux = hit(address, OFF_MODE) ? {24'h000000, modeCtl_reg} :
                    hit(address, OFF_PRESCALE) ? {15'h0000, prescaleCtl_reg} :
                    hit(address, OFF_SOURCE) ? {29'h00000000, sourceCtl_reg} :
                    hit(address, OFF_COMPARE) ? {24'h000000, compare_reg} :
                    hit(address, OFF_RELOAD) ? {24'h000000, reload_reg} :
                    hit(address, OFF_CAPTURE) ? {24'h000000, capturedCount_reg} :
                    hit(address, OFF_STATUS) ? {30'h00000000, running_reg, ~clearHold_reg} :
                    32'h00000000;

   // One wait state: readdata is latched while waitrequest is still high
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         waitReq_reg <= 1'b1;
         readData_reg <= 32'h00000000;
      end else begin
         waitReq_reg <= ~(busReq & waitReq_reg);
         if (busReq & waitReq_reg) begin
            readData_reg <= readMux;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         modeCtl_reg <= MODE_RESET;
         prescaleCtl_reg <= PRESCALE_RESET;
         sourceCtl_reg <= SOURCE_RESET;
         compare_reg <= COMPARE_RESET;
         reload_reg <= RELOAD_RESET;
      end else if (busWrite) begin
         if (hit(address, OFF_MODE)) modeCtl_reg <= writedata[7:0];
         if (hit(address, OFF_PRESCALE)) prescaleCtl_reg <= writedata[16:0];
         if (hit(address, OFF_SOURCE)) sourceCtl_reg <= writedata[2:0];
         if (hit(address, OFF_COMPARE)) compare_reg <= writedata[7:0];
         if (hit(address, OFF_RELOAD)) reload_reg <= writedata[7:0];
      end
   end

   // ******************************************
   // Pin synchronisers
   // ******************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tickSync_reg <= 3'h0;
         clearSync_reg <= 3'h0;
         gateSync_reg <= 3'h0;
      end else begin
         tickSync_reg <= {tickSync_reg[1:0], externalTickInput};
         clearSync_reg <= {clearSync_reg[1:0], counterClearInput};
         gateSync_reg <= {gateSync_reg[1:0], runGateInput};
      end
   end

   wire tickPinRise = tickSync_reg[1] & ~tickSync_reg[2];
   wire clearPin = clearSync_reg[1];
   wire clearPinRise = clearSync_reg[1] & ~clearSync_reg[2];
   wire gatePin = gateSync_reg[1];
   wire gatePinRise = gateSync_reg[1] & ~gateSync_reg[2];
   wire gatePinFall = ~gateSync_reg[1] & gateSync_reg[2];

   // ******************************************
   // Control decode
   // ******************************************
   wire pwmMode = modeCtl_reg[MODE_PWM];
   wire [1:0] irqEdgeSel = modeCtl_reg[MODE_IRQ_EDGE_LO +: 2];
   wire irqOnEdges = modeCtl_reg[MODE_IRQ_SOURCE];
   wire waveSelPulse = prescaleCtl_reg[PRE_WAVE_SEL];
   wire tickExt = sourceCtl_reg[SRC_TICK_EXT];
   wire clearExt = sourceCtl_reg[SRC_CLEAR_EXT];
   wire gateExt = sourceCtl_reg[SRC_GATE_EXT];

   // [R5] [R7] clear source
   wire clearNow = clearExt ? (modeCtl_reg[MODE_CLEAR_EDGE] ? clearPinRise : clearPin) :
                   ~modeCtl_reg[MODE_CLEAR_RELEASE];
   // [R3] [R6] [R8] gate source
   wire gateNow = gateExt ? (modeCtl_reg[MODE_GATE_EDGE] ? gateToggle_reg : gatePin) :
                  modeCtl_reg[MODE_RUN_GATE];
   wire runNow = ~clearNow & gateNow;
   wire starting = runNow & ~running_reg;
   wire stopping = running_reg & ~runNow;

   // [R9] edge gate toggles, cleared back to idle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gateToggle_reg <= 1'b0;
      end else if (clearNow) begin
         gateToggle_reg <= 1'b0;
      end else if (gatePinRise) begin
         gateToggle_reg <= ~gateToggle_reg;
      end
   end

   // ******************************************
   // Prescaler
   // ******************************************
   // [R4] source event is every master cycle or external tick edge
   wire preEvent = tickExt ? tickPinRise : 1'b1;
   wire preWrap = preEvent & (prescaleCnt_reg >= prescaleCtl_reg[15:0]);
   wire tick = preWrap;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prescaleCnt_reg <= 16'h0000;
      end else if (preWrap) begin
         prescaleCnt_reg <= 16'h0000;
      end else if (preEvent) begin
         prescaleCnt_reg <= prescaleCnt_reg + 16'h0001;
      end
   end

   // ******************************************
   // Counter
   // ******************************************
   // [R24] timer wraps at compare; [R14] PWM wraps at top
   wire [7:0] countInc = count_reg + 8'h01;
   wire timerWrap = (countInc >= compareShadow_reg);
   wire pwmWrap = (countInc == COUNT_TOP);
   // [R1] mode picks wrap point and restart value
   wire phaseEnd = pwmMode ? pwmWrap : timerWrap;
   // [R12] [R17] live reload is used, so a write takes effect at once
   wire [7:0] restartVal = pwmMode ? reload_reg : 8'h00;
   wire countStep = running_reg & runNow & tick;
   logic [7:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (clearNow) begin
         count_next = 8'h00;
      end else if (starting) begin
         count_next = restartVal;
      end else if (countStep) begin
         // [R2] increment per tick
         count_next = phaseEnd ? restartVal : countInc;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count_reg <= 8'h00;
         running_reg <= 1'b0;
         clearHold_reg <= 1'b1;
      end else begin
         count_reg <= count_next;
         running_reg <= runNow;
         clearHold_reg <= clearNow;
      end
   end

   // [R16] compare shadow only refreshes between phases
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         compareShadow_reg <= COMPARE_RESET;
      end else if (clearNow | ~running_reg | (countStep & phaseEnd)) begin
         compareShadow_reg <= compare_reg;
      end
   end

   // [R8] capture on every stop of counting
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         capturedCount_reg <= 8'h00;
      end else if (stopping) begin
         capturedCount_reg <= count_reg;
      end
   end

   // ******************************************
   // Output wave
   // ******************************************
   // [R13] [R15] PWM high below compare
   wire pwmLevel = (count_reg < compareShadow_reg);
   // [R10] [R11] square or single-tick pulse
   wire timerLevel = waveSelPulse ? (count_reg == 8'h00) : (count_reg < {1'b0, compareShadow_reg[7:1]});
   logic wave_next;

   always_comb begin
      wave_next = wave_reg;
      if (clearNow) begin
         wave_next = 1'b0;
      end else if (running_reg & runNow) begin
         wave_next = pwmMode ? pwmLevel : timerLevel;
      end else if (starting) begin
         wave_next = 1'b1;
      end
      // [R18] stopped: level held
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wave_reg <= 1'b0;
      end else begin
         wave_reg <= wave_next;
      end
   end

   // [R19] registered complement pin
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         invOut_reg <= 1'b0;
      end else begin
         invOut_reg <= ~wave_next & ~clearNow;
      end
   end

   // ******************************************
   // Interrupt request
   // ******************************************
   wire waveRise = wave_next & ~wave_reg;
   wire waveFall = ~wave_next & wave_reg;
   wire clearRise = clearNow & ~clearHold_reg;
   // [R21] start also counts as rising
   wire riseEvt = waveRise | starting;
   // [R22] clear raises falling irq
   wire fallEvt = waveFall | clearRise;
   // [R22] external gate low raises stop irq even when off
   wire stopEvt = stopping | (gateExt & gatePinFall);
   // [R20] source and edge selection
   wire edgeEvt = (irqEdgeSel == IRQ_EDGE_FALL) ? fallEvt :
                  (irqEdgeSel == IRQ_EDGE_RISE) ? riseEvt :
                  (irqEdgeSel == IRQ_EDGE_BOTH) ? (riseEvt | fallEvt) : 1'b0;
   wire irq_next = irqOnEdges ? edgeEvt : stopEvt;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // ******************************************
   // Outputs
   // ******************************************
   assign readdata = readData_reg;
   assign waitrequest = waitReq_reg;
   assign irqPulse = irq_reg;
   assign outputPinTrue = wave_reg;
   assign outputPinInverted = invOut_reg;
   // [R19] pins released while cleared; clearHold resets high
   assign outputPinTrueOe_n = clearHold_reg;
   assign outputPinInvertedOe_n = clearHold_reg;

   // ******************************************
   // Assertions
   // ******************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence reqSeen_s;
      busReq & waitReq_reg;
   endsequence
   sequence ackGiven_s;
      ~waitReq_reg ##1 waitReq_reg;
   endsequence

   bus_answer_a: assert property (reqSeen_s |=> ackGiven_s)
      else $error("bus answer missing");
   // [R5]
   clear_holds_a: assert property (clearNow |=> count_reg == 8'h00) // [R5]
      else $error("counter not held in clear");
   // [R19]
   pin_float_a: assert property (clearNow |=> outputPinTrueOe_n & outputPinInvertedOe_n) // [R19]
      else $error("output driven while cleared");
   // [R12]
   pwm_reload_a: assert property (pwmMode & ~clearNow & starting |=> count_reg == $past(reload_reg)) // [R12]
      else $error("reload not loaded at start");
   // [R24]
   timer_wrap_a: assert property (~pwmMode & ~clearNow & runNow & countStep & timerWrap & ~starting
      |=> count_reg == 8'h00) // [R24]
      else $error("timer did not restart");
   // [R15]
   pwm_full_a: assert property (pwmMode & running_reg & runNow & compareShadow_reg == COUNT_TOP & ~clearNow
      |=> wave_reg) // [R15]
      else $error("pwm not high at top compare");
   // [R8]
   capture_a: assert property (stopping |=> capturedCount_reg == $past(count_reg)) // [R8]
      else $error("count not captured at stop");
   // [R23]
   status_a: assert property (busReq & waitReq_reg & hit(address, OFF_STATUS)
      |=> readdata[1:0] == {$past(running_reg), ~$past(clearHold_reg)}) // [R23]
      else $error("status readback wrong");
   // [R21]
   start_irq_a: assert property (irqOnEdges & irqEdgeSel == IRQ_EDGE_RISE & starting |=> irqPulse) // [R21]
      else $error("no irq on start");
   // [R18]
   pwm_hold_a: assert property (pwmMode & ~running_reg & ~runNow & ~clearNow |=> $stable(wave_reg)) // [R18]
      else $error("output changed while stopped");
   // [R19] complement pin
   inv_pin_a: assert property (~clearHold_reg |-> outputPinInverted == ~outputPinTrue) // [R19]
      else $error("inverted pin not complement");
endmodule

// [rtl/tpu_pkg.sv]
package tpu_pkg;
   // ******************************************
   // Register byte offsets
   // ******************************************
   localparam logic [4:0] OFF_MODE = 5'h00;
   localparam logic [4:0] OFF_PRESCALE = 5'h04;
   localparam logic [4:0] OFF_SOURCE = 5'h08;
   localparam logic [4:0] OFF_COMPARE = 5'h0c;
   localparam logic [4:0] OFF_RELOAD = 5'h10;
   localparam logic [4:0] OFF_CAPTURE = 5'h14;
   localparam logic [4:0] OFF_STATUS = 5'h18;
   // ******************************************
   // Field positions
   // ******************************************
   localparam int MODE_CLEAR_RELEASE = 0;
   localparam int MODE_CLEAR_EDGE = 1;
   localparam int MODE_RUN_GATE = 2;
   localparam int MODE_GATE_EDGE = 3;
   localparam int MODE_IRQ_EDGE_LO = 4;
   localparam int MODE_IRQ_SOURCE = 6;
   localparam int MODE_PWM = 7;
   localparam int PRE_WAVE_SEL = 16;
   localparam int SRC_TICK_EXT = 0;
   localparam int SRC_CLEAR_EXT = 1;
   localparam int SRC_GATE_EXT = 2;
   localparam int STAT_RELEASED = 0;
   localparam int STAT_RUNNING = 1;
   // ******************************************
   // Reset values and encodings
   // ******************************************
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [16:0] PRESCALE_RESET = 17'h00000;
   localparam logic [2:0] SOURCE_RESET = 3'h0;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] COUNT_TOP = 8'hff;
   localparam logic [1:0] IRQ_EDGE_FALL = 2'h0;
   localparam logic [1:0] IRQ_EDGE_RISE = 2'h1;
   localparam logic [1:0] IRQ_EDGE_BOTH = 2'h2;
endpackage

// [verif/tpu_far_side.sv]
`timescale 1ns/1ns
// ******************************
// Far side: pins and load
// ******************************
module tpu_far_side #(
   parameter int TICK_CYCLES = 8
) (
   // Clock and controls from the bench
   input wire logic sys_clk,
   input wire logic tickEn,
   input wire logic clearLevel,
   input wire logic gateLevel,
   // Pins toward the unit
   output logic externalTickInput,
   output logic counterClearInput,
   output logic runGateInput,
   // Load side
   input wire logic outputPinTrue,
   input wire logic outputPinTrueOe_n,
   output logic pinTrueLevel
);
   int tickCnt;
   // Tick well below half the master rate; stands still when disabled
   always_ff @(posedge sys_clk) begin
      tickCnt <= tickEn ? (tickCnt + 1) % TICK_CYCLES : 0;
   end
   assign externalTickInput = tickEn && tickCnt < TICK_CYCLES / 2;
   assign counterClearInput = clearLevel;
   assign runGateInput = gateLevel;
   assign pinTrueLevel = outputPinTrueOe_n ? 1'b1 : outputPinTrue;
endmodule

// [verif/tpu_timer_tb.sv]
`timescale 1ns/1ns
module tpu_timer_tb
   import tpu_pkg::*;
();
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic tickEn = 1'b0;
   logic clrLevel = 1'b0;
   logic gateLevel = 1'b0;
   wire [31:0] readdata;
   wire waitrequest, extTick, clrPin, gatePin, outTrue, oeTrue, outInv, oeInv, irqPulse, pinTrue;
   logic [31:0] rd;
   logic [7:0] irqMode [3] = '{8'hd5, 8'hc5, 8'he5};
   int errors = 0;
   int comparisons = 0;
   int per, hi, irqs, cmp, rel, pre, k;
   logic lvl;

   always #25 sys_clk = ~sys_clk;

   tpu_timer dut_u (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .externalTickInput(extTick), .counterClearInput(clrPin), .runGateInput(gatePin),
      .outputPinTrue(outTrue), .outputPinTrueOe_n(oeTrue), .outputPinInverted(outInv),
      .outputPinInvertedOe_n(oeInv), .irqPulse(irqPulse));

   tpu_far_side #(.TICK_CYCLES(8)) far_u (.sys_clk(sys_clk), .tickEn(tickEn), .clearLevel(clrLevel),
      .gateLevel(gateLevel), .externalTickInput(extTick), .counterClearInput(clrPin),
      .runGateInput(gatePin), .outputPinTrue(outTrue), .outputPinTrueOe_n(oeTrue),
      .pinTrueLevel(pinTrue));

   // ******************************
   // Shared tasks
   // ******************************
   function automatic int timer_per(int c, int p);
      return c * (p + 1);
   endfunction

   function automatic int pwm_per(int r);
      return 255 - r;
   endfunction

   task automatic tally_and_finish();
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50) begin
         errors++;
         tally_and_finish();
      end
   endtask

   // Second rise-to-rise window: period, high cycles, irq pulses
   task automatic measure(output int p, output int h, output int q);
      int n;
      logic last;
      n = 0;
      p = 0;
      h = 0;
      q = 0;
      for (int e = 0; e < 3; e++) begin
         do begin
            last = pinTrue;
            @(negedge sys_clk);
            n++;
            if (e == 2) begin
               p++;
               h += (pinTrue === 1'b1);
               q += (irqPulse === 1'b1);
            end
         end while (!(last === 1'b0 && pinTrue === 1'b1) && n < 3000);
      end
      if (n >= 3000) begin
         errors++;
         tally_and_finish();
      end
   endtask

   task automatic level_count(input int len, output int h);
      h = 0;
      repeat (len) begin
         @(negedge sys_clk);
         h += (pinTrue === 1'b1);
      end
   endtask

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      void'($urandom(32'hcb0e1ba3));
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      check({oeTrue, oeInv, pinTrue, outInv}, 4'he);
      for (k = 0; k < 8; k++) begin
         bus(1'b0, 5'(k * 4), 0);
         check(rd, 0);
      end
      bus(1'b1, OFF_CAPTURE, 32'hff);
      bus(1'b0, OFF_CAPTURE, 0);
      check(rd, 0);
      $display("test registers done");
      for (k = 0; k < 3; k++) begin
         cmp = 2 * (1 + $urandom_range(0, 15));
         pre = $urandom_range(0, 3);
         bus(1'b1, OFF_COMPARE, cmp);
         bus(1'b1, OFF_PRESCALE, pre);
         bus(1'b1, OFF_MODE, 32'h05);
         measure(per, hi, irqs);
         check(per, timer_per(cmp, pre));
         check(hi, timer_per(cmp / 2, pre));
         bus(1'b1, OFF_PRESCALE, pre | 32'h10000);
         measure(per, hi, irqs);
         check(hi, pre + 1);
         check(per, timer_per(cmp, pre));
         check({outInv, oeInv}, 2'h0);
         bus(1'b0, OFF_STATUS, 0);
         check(rd, 3);
         bus(1'b1, OFF_MODE, 0);
         // Pins float one cycle after the clear lands
         repeat (2) @(negedge sys_clk);
         check({oeTrue, pinTrue}, 2'h3);
      end
      $display("test timer done");
      bus(1'b1, OFF_SOURCE, 1);
      bus(1'b1, OFF_COMPARE, 4);
      tickEn <= 1'b1;
      for (pre = 0; pre < 2; pre++) begin
         bus(1'b1, OFF_PRESCALE, pre);
         bus(1'b1, OFF_MODE, 32'h05);
         measure(per, hi, irqs);
         check(per, 8 * timer_per(4, pre));
         bus(1'b1, OFF_MODE, 0);
      end
      tickEn <= 1'b0;
      bus(1'b1, OFF_PRESCALE, 0);
      $display("test external tick done");
      bus(1'b1, OFF_SOURCE, 2);
      bus(1'b1, OFF_MODE, 32'h05);
      clrLevel <= 1'b1;
      repeat (6) @(posedge sys_clk);
      level_count(100, hi);
      check(hi, 100);
      bus(1'b1, OFF_MODE, 32'h07);
      measure(per, hi, irqs);
      check(per, timer_per(4, 0));
      clrLevel <= 1'b0;
      bus(1'b1, OFF_MODE, 0);
      $display("test external clear done");
      bus(1'b1, OFF_SOURCE, 4);
      bus(1'b1, OFF_MODE, 32'h05);
      for (k = 1; k >= 0; k--) begin
         gateLevel <= k[0];
         repeat (8) @(posedge sys_clk);
         bus(1'b0, OFF_STATUS, 0);
         check(rd[1], k[0]);
      end
      bus(1'b1, OFF_MODE, 0);
      bus(1'b1, OFF_MODE, 32'h0d);
      for (k = 0; k < 3; k++) begin
         gateLevel <= 1'b1;
         repeat (8) @(posedge sys_clk);
         gateLevel <= 1'b0;
         repeat (8) @(posedge sys_clk);
         bus(1'b0, OFF_STATUS, 0);
         check(rd[1], k[0] == 0);
      end
      bus(1'b1, OFF_MODE, 0);
      bus(1'b1, OFF_SOURCE, 0);
      $display("test external gate done");
      for (k = 0; k < 3; k++) begin
         rel = $urandom_range(0, 100);
         cmp = $urandom_range(rel + 1, 254);
         bus(1'b1, OFF_MODE, 0);
         bus(1'b1, OFF_RELOAD, rel);
         bus(1'b1, OFF_COMPARE, cmp);
         bus(1'b1, OFF_MODE, irqMode[k]);
         measure(per, hi, irqs);
         check(per, pwm_per(rel));
         check(hi, cmp - rel);
         check(irqs, (k == 2) ? 2 : 1);
      end
      bus(1'b1, OFF_MODE, 32'he1);
      repeat (3) @(posedge sys_clk);
      lvl = pinTrue;
      level_count(300, hi);
      check(hi, (lvl === 1'b1) ? 300 : 0);
      $display("test pwm done");
      bus(1'b1, OFF_RELOAD, 20);
      for (k = 0; k < 3; k++) begin
         cmp = (k == 0) ? 255 : ((k == 1) ? 0 : 10);
         bus(1'b1, OFF_MODE, 0);
         bus(1'b1, OFF_COMPARE, cmp);
         bus(1'b1, OFF_MODE, 32'h85);
         repeat (5) @(posedge sys_clk);
         level_count(600, hi);
         check(hi, (cmp == 255) ? 600 : 0);
         check(outInv, (cmp == 255) ? 0 : 1);
      end
      $display("test pwm limits done");
      tally_and_finish();
   end
endmodule
